// ---- src/spd_dev.sv ----
`timescale 1ns/1ps
module spd_dev #(
	parameter int FLASH_AW = spd_pkg::FLASH_AW,
	parameter int PAGE_AW = spd_pkg::PAGE_AW,
	parameter int EE_AW = spd_pkg::EE_AW,
	parameter int EE_PAGE_AW = spd_pkg::EE_PAGE_AW,
	parameter int FLASH_WAIT = spd_pkg::FLASH_CYC,
	parameter int EE_WAIT = spd_pkg::EE_CYC,
	parameter int FUSE_WAIT = spd_pkg::FUSE_CYC,
	parameter int ERASE_WAIT = spd_pkg::ERASE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	spd_link_if.dev link,
	output logic enabled_o,
	output logic busy_o
);
	localparam int FLASH_WORDS = 1 << FLASH_AW;
	localparam int PAGE_WORDS = 1 << PAGE_AW;
	localparam int EE_WORDS = 1 << EE_AW;
	localparam int EE_PAGE = 1 << EE_PAGE_AW;

	generate
		if (FLASH_AW > 16 || EE_AW > 16 || PAGE_AW >= FLASH_AW || PAGE_AW > 8 || EE_PAGE_AW > 8
			|| EE_PAGE_AW >= EE_AW || EE_AW > FLASH_AW || PAGE_AW < 1 || EE_PAGE_AW < 1)
		begin : g_bad
			$error("spd_dev: unsupported memory geometry");
		end
	endgenerate

	typedef struct packed {
		logic sck_m;
		logic sck_s;
		logic sck_p;
		logic mosi_m;
		logic mosi_s;
		logic rst_m;
		logic rst_s;
		logic [31:0] rx;
		logic [4:0] bitcnt;
		logic [7:0] tx;
		logic miso;
		logic enabled;
		logic busy;
		logic [7:0] ext_adr;
		logic [7:0] fuse_lo;
		logic [7:0] fuse_hi;
		logic [7:0] fuse_ext;
		logic [7:0] lock;
		spd_pkg::spd_eng_t eng;
		logic [FLASH_AW-1:0] idx;
		logic [FLASH_AW-PAGE_AW-1:0] page;
		logic [EE_AW-1:0] ee_base;
		logic [31:0] timer;
	} spd_dev_st_t;

	spd_dev_st_t s_ff;
	spd_dev_st_t nxt_s;

	logic [15:0] flash_mem [FLASH_WORDS];
	logic [15:0] fbuf [PAGE_WORDS];
	logic [7:0] ee_mem [EE_WORDS];
	logic [7:0] ebuf [EE_PAGE];

	logic flash_we;
	logic [FLASH_AW-1:0] flash_a;
	logic [15:0] flash_d;
	logic ee_we;
	logic [EE_AW-1:0] ee_a;
	logic [7:0] ee_d;
	logic fbuf_we_lo;
	logic fbuf_we_hi;
	logic ebuf_we;
	logic [7:0] buf_d;
	logic [PAGE_AW-1:0] fbuf_i;
	logic [EE_PAGE_AW-1:0] ebuf_i;
	logic [31:0] rx_n;
	logic [7:0] op;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [15:0] adr;
	logic [7:0] rd;
	logic rise;
	logic fall;
	logic busy;
	logic eng_done;

	function automatic logic [31:0] wait_cyc(input int cyc);
		wait_cyc = (cyc < 1) ? 32'h1 : 32'(cyc);
	endfunction

	////////////////////////////////////////////////////////////////
	// Read data selection for the fourth byte
	always_comb
	begin
		rd = rx_n[7:0];
		case (op)
			spd_pkg::OP_RD_HI: rd = flash_mem[adr[FLASH_AW-1:0]][15:8];
			spd_pkg::OP_RD_LO: rd = flash_mem[adr[FLASH_AW-1:0]][7:0];
			spd_pkg::OP_RD_EE: rd = ee_mem[adr[EE_AW-1:0]];
			spd_pkg::OP_RD_FUSE:
			begin
				if (b2 == spd_pkg::SUB_ZERO)
					rd = s_ff.fuse_lo;
				else if (b2 == spd_pkg::SUB_HIGH)
					rd = s_ff.fuse_ext;
			end
			spd_pkg::OP_RD_HFUSE:
			begin
				if (b2 == spd_pkg::SUB_ZERO)
					rd = s_ff.lock;
				else if (b2 == spd_pkg::SUB_HIGH)
					rd = s_ff.fuse_hi;
			end
			spd_pkg::OP_POLL: rd = {7'h00, busy};
			default: rd = rx_n[7:0];
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_s = s_ff;
		flash_we = 1'b0;
		flash_a = s_ff.idx;
		flash_d = {spd_pkg::ERASED, spd_pkg::ERASED};
		ee_we = 1'b0;
		ee_a = s_ff.idx[EE_AW-1:0];
		ee_d = spd_pkg::ERASED;
		fbuf_we_lo = 1'b0;
		fbuf_we_hi = 1'b0;
		ebuf_we = 1'b0;
		eng_done = 1'b0;
		nxt_s.sck_m = link.sck;
		nxt_s.sck_s = s_ff.sck_m;
		nxt_s.sck_p = s_ff.sck_s;
		nxt_s.mosi_m = link.mosi;
		nxt_s.mosi_s = s_ff.mosi_m;
		nxt_s.rst_m = link.prog_rst_n;
		nxt_s.rst_s = s_ff.rst_m;
		rx_n = {s_ff.rx[30:0], s_ff.mosi_s};
		op = rx_n[23:16];
		b2 = rx_n[15:8];
		b3 = rx_n[7:0];
		adr = {b2, b3};
		buf_d = rx_n[7:0];
		fbuf_i = rx_n[PAGE_AW+7:8];
		ebuf_i = rx_n[EE_PAGE_AW+7:8];
		rise = s_ff.sck_s & ~s_ff.sck_p;
		fall = ~s_ff.sck_s & s_ff.sck_p;
		busy = (s_ff.eng != spd_pkg::ENG_IDLE) || (s_ff.timer != 32'h0);

		// Memory engine walks one location per cycle to keep a single write port
		case (s_ff.eng)
			spd_pkg::ENG_IDLE: eng_done = 1'b0;
			spd_pkg::ENG_ERASE:
			begin
				flash_we = 1'b1;
				ee_we = (s_ff.idx >> EE_AW) == '0;
				eng_done = s_ff.idx == FLASH_AW'(FLASH_WORDS - 1);
			end
			spd_pkg::ENG_FPAGE:
			begin
				flash_we = 1'b1;
				flash_a = {s_ff.page, s_ff.idx[PAGE_AW-1:0]};
				flash_d = fbuf[s_ff.idx[PAGE_AW-1:0]];
				eng_done = s_ff.idx == FLASH_AW'(PAGE_WORDS - 1);
			end
			spd_pkg::ENG_EPAGE:
			begin
				ee_we = 1'b1;
				ee_a = s_ff.ee_base | EE_AW'(s_ff.idx[EE_PAGE_AW-1:0]);
				ee_d = ebuf[s_ff.idx[EE_PAGE_AW-1:0]];
				eng_done = s_ff.idx == FLASH_AW'(EE_PAGE - 1);
			end
			default: eng_done = 1'b1;
		endcase
		if (eng_done)
		begin
			nxt_s.eng = spd_pkg::ENG_IDLE;
			nxt_s.idx = '0;
		end
		else if (s_ff.eng != spd_pkg::ENG_IDLE)
			nxt_s.idx = s_ff.idx + 1'b1;
		if (s_ff.timer != 32'h0)
			nxt_s.timer = s_ff.timer - 32'h1;

		if (s_ff.rst_s)
		begin
			// Out of programming reset: framing and enable start over
			nxt_s.bitcnt = '0;
			nxt_s.enabled = 1'b0;
			nxt_s.tx = '0;
			nxt_s.miso = 1'b0;
		end
		else if (rise)
		begin
			nxt_s.rx = rx_n;
			nxt_s.bitcnt = s_ff.bitcnt + 1'b1;
			if (s_ff.bitcnt[2:0] == spd_pkg::BYTE_END)
			begin
				// Each byte echoes the one before, except byte four takes rd once enabled, so the enable returns 53 in byte three
				if (s_ff.bitcnt == spd_pkg::RESP_BIT && s_ff.enabled)
					nxt_s.tx = rd;
				else
					nxt_s.tx = rx_n[7:0];
			end
			if (s_ff.bitcnt == spd_pkg::LAST_BIT)
			begin
				op = rx_n[31:24];
				b2 = rx_n[23:16];
				b3 = rx_n[15:8];
				adr = {b2, b3};
				if (op == spd_pkg::OP_PROG && b2 == spd_pkg::SUB_ENABLE)
					nxt_s.enabled = 1'b1;
				else if (s_ff.enabled && !busy)
				begin
					case (op)
						spd_pkg::OP_PROG:
						begin
							case (b2)
								spd_pkg::SUB_ERASE:
								begin
									nxt_s.eng = spd_pkg::ENG_ERASE;
									nxt_s.idx = '0;
									nxt_s.timer = wait_cyc(ERASE_WAIT);
								end
								// Data stored as sent: zero is programmed, one unprogrammed
								spd_pkg::SUB_WR_LO: nxt_s.fuse_lo = buf_d;
								spd_pkg::SUB_WR_HI: nxt_s.fuse_hi = buf_d;
								spd_pkg::SUB_WR_EXT: nxt_s.fuse_ext = buf_d;
								spd_pkg::SUB_WR_LOCK: nxt_s.lock = buf_d;
								default: nxt_s.timer = s_ff.timer;
							endcase
							if (b2 == spd_pkg::SUB_WR_LO || b2 == spd_pkg::SUB_WR_HI
								|| b2 == spd_pkg::SUB_WR_EXT || b2 == spd_pkg::SUB_WR_LOCK)
								nxt_s.timer = wait_cyc(FUSE_WAIT);
						end
						spd_pkg::OP_LD_EXT: nxt_s.ext_adr = b3;
						spd_pkg::OP_LD_HI: fbuf_we_hi = 1'b1;
						spd_pkg::OP_LD_LO: fbuf_we_lo = 1'b1;
						spd_pkg::OP_LD_EE: ebuf_we = 1'b1;
						spd_pkg::OP_WR_PAGE:
						begin
							nxt_s.page = adr[FLASH_AW-1:PAGE_AW];
							nxt_s.eng = spd_pkg::ENG_FPAGE;
							nxt_s.idx = '0;
							nxt_s.timer = wait_cyc(FLASH_WAIT);
						end
						spd_pkg::OP_WR_EE:
						begin
							ee_we = 1'b1;
							ee_a = adr[EE_AW-1:0];
							ee_d = buf_d;
							nxt_s.timer = wait_cyc(EE_WAIT);
						end
						spd_pkg::OP_WR_EEPG:
						begin
							nxt_s.ee_base = adr[EE_AW-1:0] & ~EE_AW'(EE_PAGE - 1);
							nxt_s.eng = spd_pkg::ENG_EPAGE;
							nxt_s.idx = '0;
							nxt_s.timer = wait_cyc(EE_WAIT);
						end
						default: nxt_s.timer = nxt_s.timer;
					endcase
				end
			end
		end
		else if (fall)
		begin
			nxt_s.miso = s_ff.tx[7];
			nxt_s.tx = {s_ff.tx[6:0], 1'b0};
		end
		nxt_s.busy = (nxt_s.eng != spd_pkg::ENG_IDLE) || (nxt_s.timer != 32'h0);
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s_ff <= '0;
			s_ff.rst_m <= 1'b1;
			s_ff.rst_s <= 1'b1;
			s_ff.fuse_lo <= spd_pkg::CFG_RESET;
			s_ff.fuse_hi <= spd_pkg::CFG_RESET;
			s_ff.fuse_ext <= spd_pkg::CFG_RESET;
			s_ff.lock <= spd_pkg::CFG_RESET;
		end
		else
			s_ff <= nxt_s;
	end

	// Arrays carry no reset; their contents are nonvolatile in intent
	always_ff @(posedge ref_clk_i)
	begin
		if (flash_we)
			flash_mem[flash_a] <= flash_d;
		if (ee_we)
			ee_mem[ee_a] <= ee_d;
		if (fbuf_we_lo)
			fbuf[fbuf_i][7:0] <= buf_d;
		if (fbuf_we_hi)
			fbuf[fbuf_i][15:8] <= buf_d;
		if (ebuf_we)
			ebuf[ebuf_i] <= buf_d;
	end

	assign link.miso = s_ff.miso;
	assign enabled_o = s_ff.enabled;
	assign busy_o = s_ff.busy;
endmodule

// ---- src/spd_pkg.sv ----
// Behaviour
// - Instructions are four bytes; enable is AC 53.
// - AC 80 erases all flash and EEPROM.
// - Opcode 4D loads extended address from byte three.
// - Opcode 48 loads high byte into page buffer.
// - Opcode 40 loads low byte into page buffer.
// - Opcode C1 loads EEPROM page buffer byte.
// - Byte four returns flash high, low, EEPROM data.
// - Byte four returns fuses or lock bits.
// - Opcode 4C commits flash buffer to page.
// - C0 writes one EEPROM byte; C2 commits page.
// - AC A0/A8/A4/E0 writes fuse or lock set.
// - Fuse bit zero programmed, one unprogrammed.
// - Poll F0 returns LSB one while busy.
// - Programmer waits until busy bit reads zero.
// - Programmer loads low byte before high byte.
// - Programmer commits filled EEPROM page buffer.
// - Programmer leaves unused fuses at one.
// - Third enable byte echoes 53, else reset, retry.
// - Device samples input on rising serial clock.
// - Device changes output on falling serial clock.
// - Erase leaves every location at FF.
package spd_pkg;
	localparam logic [7:0] OP_PROG = 8'hac;
	localparam logic [7:0] SUB_ENABLE = 8'h53;
	localparam logic [7:0] SUB_ERASE = 8'h80;
	localparam logic [7:0] SUB_WR_LO = 8'ha0;
	localparam logic [7:0] SUB_WR_HI = 8'ha8;
	localparam logic [7:0] SUB_WR_EXT = 8'ha4;
	localparam logic [7:0] SUB_WR_LOCK = 8'he0;
	localparam logic [7:0] SUB_ZERO = 8'h00;
	localparam logic [7:0] SUB_HIGH = 8'h08;
	localparam logic [7:0] OP_POLL = 8'hf0;
	localparam logic [7:0] OP_LD_EXT = 8'h4d;
	localparam logic [7:0] OP_LD_HI = 8'h48;
	localparam logic [7:0] OP_LD_LO = 8'h40;
	localparam logic [7:0] OP_LD_EE = 8'hc1;
	localparam logic [7:0] OP_RD_HI = 8'h28;
	localparam logic [7:0] OP_RD_LO = 8'h20;
	localparam logic [7:0] OP_RD_EE = 8'ha0;
	localparam logic [7:0] OP_RD_FUSE = 8'h50;
	localparam logic [7:0] OP_RD_HFUSE = 8'h58;
	localparam logic [7:0] OP_WR_PAGE = 8'h4c;
	localparam logic [7:0] OP_WR_EE = 8'hc0;
	localparam logic [7:0] OP_WR_EEPG = 8'hc2;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] CFG_RESET = 8'hff;
	localparam logic [4:0] LAST_BIT = 5'h1f;
	localparam logic [4:0] RESP_BIT = 5'h17;
	localparam logic [2:0] BYTE_END = 3'h7;
	localparam int FLASH_AW = 13;
	localparam int PAGE_AW = 6;
	localparam int EE_AW = 9;
	localparam int EE_PAGE_AW = 2;
	localparam int CLK_HZ = 20_000_000;
	localparam int T_FLASH_US = 4500;
	localparam int T_EE_US = 9000;
	localparam int T_FUSE_US = 4500;
	localparam int T_ERASE_US = 9000;
	localparam int FLASH_CYC = T_FLASH_US * (CLK_HZ / 1_000_000);
	localparam int EE_CYC = T_EE_US * (CLK_HZ / 1_000_000);
	localparam int FUSE_CYC = T_FUSE_US * (CLK_HZ / 1_000_000);
	localparam int ERASE_CYC = T_ERASE_US * (CLK_HZ / 1_000_000);
	localparam int HALF_CYC = 8;
	localparam int RST_PULSE_CYC = 4;
	typedef enum logic [1:0] {ENG_IDLE, ENG_ERASE, ENG_FPAGE, ENG_EPAGE} spd_eng_t;
	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_RST} spd_hst_t;
endpackage

// ---- src/spd_link_if.sv ----
`timescale 1ns/1ps
interface spd_link_if;
	logic sck;
	logic mosi;
	logic miso;
	logic prog_rst_n;
	modport dev (input sck, input mosi, input prog_rst_n, output miso);
	modport host (output sck, output mosi, output prog_rst_n, input miso);
endinterface

// ---- src/spd_host.sv ----
`timescale 1ns/1ps
module spd_host #(
	parameter int HALF = spd_pkg::HALF_CYC,
	parameter int RST_PULSE = spd_pkg::RST_PULSE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	spd_link_if.host link,
	input wire logic prog_mode_i,
	input wire logic cmd_valid_i,
	input wire logic [31:0] cmd_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [31:0] rsp_o,
	output logic sync_ok_o,
	output logic order_err_o,
	output logic ee_pend_o
);
	generate
		if (HALF < 8 || HALF > 65535 || RST_PULSE < 2 || RST_PULSE > 32767)
		begin : g_bad
			$error("spd_host: serial clock half period or reset pulse out of range");
		end
	endgenerate

	typedef struct packed {
		logic miso_m;
		logic miso_s;
		spd_pkg::spd_hst_t st;
		logic [31:0] cur;
		logic [31:0] tx;
		logic [31:0] rx;
		logic [31:0] res;
		logic [4:0] bitcnt;
		logic [15:0] div;
		logic [15:0] cnt;
		logic sck;
		logic mosi;
		logic prog_rst_n;
		logic polling;
		logic cmd_ready;
		logic rsp_valid;
		logic [31:0] rsp;
		logic sync_ok;
		logic order_err;
		logic lo_ok;
		logic [15:0] lo_adr;
		logic ee_pend;
	} spd_hst_st_t;

	spd_hst_st_t s_ff;
	spd_hst_st_t nxt_s;

	function automatic logic needs_poll(input logic [31:0] c);
		needs_poll = (c[31:24] == spd_pkg::OP_PROG && c[23:16] != spd_pkg::SUB_ENABLE)
			|| c[31:24] == spd_pkg::OP_WR_PAGE || c[31:24] == spd_pkg::OP_WR_EE
			|| c[31:24] == spd_pkg::OP_WR_EEPG;
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.miso_m = link.miso;
		nxt_s.miso_s = s_ff.miso_m;
		nxt_s.rsp_valid = 1'b0;
		nxt_s.order_err = 1'b0;
		nxt_s.prog_rst_n = ~prog_mode_i;
		case (s_ff.st)
			spd_pkg::H_IDLE:
			begin
				nxt_s.sck = 1'b0;
				if (cmd_valid_i && s_ff.cmd_ready)
				begin
					if (cmd_i[31:24] == spd_pkg::OP_LD_HI && (!s_ff.lo_ok || cmd_i[23:8] != s_ff.lo_adr))
						nxt_s.order_err = 1'b1;
					else
					begin
						nxt_s.cur = cmd_i;
						nxt_s.tx = cmd_i;
						nxt_s.mosi = cmd_i[31];
						nxt_s.bitcnt = '0;
						nxt_s.div = '0;
						nxt_s.polling = 1'b0;
						nxt_s.st = spd_pkg::H_SHIFT;
						if (cmd_i[31:24] == spd_pkg::OP_LD_LO)
						begin
							nxt_s.lo_ok = 1'b1;
							nxt_s.lo_adr = cmd_i[23:8];
						end
						else if (cmd_i[31:24] == spd_pkg::OP_LD_HI)
							nxt_s.lo_ok = 1'b0;
						if (cmd_i[31:24] == spd_pkg::OP_LD_EE)
							nxt_s.ee_pend = 1'b1;
						else if (cmd_i[31:24] == spd_pkg::OP_WR_EEPG)
							nxt_s.ee_pend = 1'b0;
					end
				end
			end
			spd_pkg::H_SHIFT:
			begin
				nxt_s.div = s_ff.div + 16'h1;
				if (s_ff.div == 16'(HALF - 1))
				begin
					nxt_s.div = '0;
					if (!s_ff.sck)
					begin
						nxt_s.sck = 1'b1;
						nxt_s.rx = {s_ff.rx[30:0], s_ff.miso_s};
					end
					else
					begin
						nxt_s.sck = 1'b0;
						nxt_s.tx = {s_ff.tx[30:0], 1'b0};
						nxt_s.mosi = s_ff.tx[30];
						if (s_ff.bitcnt == spd_pkg::LAST_BIT)
							nxt_s.st = spd_pkg::H_END;
						else
							nxt_s.bitcnt = s_ff.bitcnt + 1'b1;
					end
				end
			end
			spd_pkg::H_END:
			begin
				nxt_s.st = spd_pkg::H_IDLE;
				nxt_s.bitcnt = '0;
				nxt_s.div = '0;
				if (s_ff.cur[31:16] == {spd_pkg::OP_PROG, spd_pkg::SUB_ENABLE})
				begin
					nxt_s.sync_ok = s_ff.rx[15:8] == spd_pkg::SUB_ENABLE;
					if (s_ff.rx[15:8] != spd_pkg::SUB_ENABLE)
					begin
						nxt_s.st = spd_pkg::H_RST;
						nxt_s.cnt = '0;
					end
					else
					begin
						nxt_s.rsp_valid = 1'b1;
						nxt_s.rsp = s_ff.rx;
					end
				end
				else if (s_ff.polling ? s_ff.rx[0] : needs_poll(s_ff.cur))
				begin
					if (!s_ff.polling)
						nxt_s.res = s_ff.rx;
					nxt_s.polling = 1'b1;
					nxt_s.tx = {spd_pkg::OP_POLL, 24'h000000};
					nxt_s.mosi = spd_pkg::OP_POLL[7];
					nxt_s.st = spd_pkg::H_SHIFT;
				end
				else
				begin
					nxt_s.rsp_valid = 1'b1;
					nxt_s.rsp = s_ff.polling ? s_ff.res : s_ff.rx;
				end
			end
			spd_pkg::H_RST:
			begin
				// High for one pulse, then low again before the enable is resent
				nxt_s.cnt = s_ff.cnt + 16'h1;
				nxt_s.prog_rst_n = s_ff.cnt < 16'(RST_PULSE);
				if (s_ff.cnt == 16'(2 * RST_PULSE - 1))
				begin
					nxt_s.tx = s_ff.cur;
					nxt_s.mosi = s_ff.cur[31];
					nxt_s.st = spd_pkg::H_SHIFT;
				end
			end
			default: nxt_s.st = spd_pkg::H_IDLE;
		endcase
		if (!prog_mode_i)
		begin
			nxt_s.st = spd_pkg::H_IDLE;
			nxt_s.sck = 1'b0;
			nxt_s.sync_ok = 1'b0;
		end
		nxt_s.cmd_ready = (nxt_s.st == spd_pkg::H_IDLE) && prog_mode_i && !nxt_s.order_err;
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s_ff <= '0;
			s_ff.prog_rst_n <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	assign link.sck = s_ff.sck;
	assign link.mosi = s_ff.mosi;
	assign link.prog_rst_n = s_ff.prog_rst_n;
	assign cmd_ready_o = s_ff.cmd_ready;
	assign rsp_valid_o = s_ff.rsp_valid;
	assign rsp_o = s_ff.rsp;
	assign sync_ok_o = s_ff.sync_ok;
	assign order_err_o = s_ff.order_err;
	assign ee_pend_o = s_ff.ee_pend;
endmodule

// ---- test/spd_monitor.sv ----
`timescale 1ns/1ps
module spd_monitor (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic prog_rst_n
);
	typedef struct packed {
		logic sck;
		logic [3:0] since_fall;
		logic [4:0] cnt;
		logic [31:0] rx;
		logic [31:0] tx;
		logic done;
		logic [31:0] rxw;
		logic [31:0] txw;
		logic en;
		logic was_wr;
		logic was_poll;
	} spd_mon_t;
	spd_mon_t mon_ff;
	spd_mon_t nxt_mon;

	////////////////////////////////////////////////////////////////
	// Rebuilds the instruction framing from the wire alone
	always_comb
	begin
		nxt_mon = mon_ff;
		nxt_mon.sck = sck;
		nxt_mon.done = 1'b0;
		if (mon_ff.since_fall != 4'hf)
			nxt_mon.since_fall = mon_ff.since_fall + 4'h1;
		if (mon_ff.sck && !sck)
			nxt_mon.since_fall = 4'h0;
		if (sck && !mon_ff.sck)
		begin
			nxt_mon.rx = {mon_ff.rx[30:0], mosi};
			nxt_mon.tx = {mon_ff.tx[30:0], miso};
			nxt_mon.cnt = mon_ff.cnt + 5'h1;
			nxt_mon.done = (mon_ff.cnt == 5'h1f);
			nxt_mon.rxw = {mon_ff.rx[30:0], mosi};
			nxt_mon.txw = {mon_ff.tx[30:0], miso};
		end
		if (mon_ff.done)
		begin
			nxt_mon.en = mon_ff.en | (mon_ff.rxw[31:16] == 16'hac53 && mon_ff.txw[15:8] == 8'h53);
			nxt_mon.was_poll = (mon_ff.rxw[31:24] == spd_pkg::OP_POLL);
			nxt_mon.was_wr = mon_ff.en && ((mon_ff.rxw[31:24] == spd_pkg::OP_PROG
				&& mon_ff.rxw[23:16] != spd_pkg::SUB_ENABLE)
				|| mon_ff.rxw[31:24] inside {spd_pkg::OP_WR_PAGE, spd_pkg::OP_WR_EE, spd_pkg::OP_WR_EEPG});
		end
		// Leaving programming mode drops framing and enable, as the device does
		if (prog_rst_n)
		begin
			nxt_mon.cnt = 5'h0;
			nxt_mon.en = 1'b0;
			nxt_mon.was_wr = 1'b0;
			nxt_mon.was_poll = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			mon_ff <= '0;
		else
			mon_ff <= nxt_mon;
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_sck_high;
		$rose(sck) |=> sck [*7];
	endproperty
	a_sck_high: assert property (p_sck_high) else $error("serial clock high phase too short");
	property p_sck_low;
		$fell(sck) && !prog_rst_n |=> !sck [*7];
	endproperty
	a_sck_low: assert property (p_sck_low) else $error("serial clock low phase too short");
	property p_mosi_hold;
		$rose(sck) |=> $stable(mosi) [*4];
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("input data moved near rising clock");
	property p_miso_fall;
		$changed(miso) && !prog_rst_n && !$past(prog_rst_n) |-> mon_ff.since_fall inside {[1:6]};
	endproperty
	a_miso_fall: assert property (p_miso_fall) else $error("output data moved away from falling clock");
	property p_idle_sck;
		$fell(prog_rst_n) |-> !sck [*4];
	endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("serial clock too soon after mode entry");
	property p_echo_b2;
		mon_ff.done |-> mon_ff.txw[23:16] == mon_ff.rxw[31:24];
	endproperty
	a_echo_b2: assert property (p_echo_b2) else $error("second output byte is not first input byte");
	property p_echo_53;
		mon_ff.done && mon_ff.rxw[31:16] == 16'hac53 |-> mon_ff.txw[15:8] == 8'h53;
	endproperty
	a_echo_53: assert property (p_echo_53) else $error("enable echo missing");
	property p_poll_busy;
		mon_ff.done && mon_ff.en && mon_ff.was_wr && mon_ff.rxw[31:24] == spd_pkg::OP_POLL |-> mon_ff.txw[0];
	endproperty
	a_poll_busy: assert property (p_poll_busy) else $error("poll right after a write reads idle");
	property p_poll_free;
		mon_ff.done && mon_ff.en && mon_ff.was_poll && mon_ff.rxw[31:24] == spd_pkg::OP_POLL |-> !mon_ff.txw[0];
	endproperty
	a_poll_free: assert property (p_poll_free) else $error("second poll still reads busy");

	c_enable: cover property (mon_ff.done && mon_ff.rxw[31:16] == 16'hac53);
	c_busy: cover property (mon_ff.done && mon_ff.was_wr && mon_ff.rxw[31:24] == spd_pkg::OP_POLL);
	c_erase: cover property (mon_ff.done && mon_ff.rxw == 32'hac800000);
endmodule

// ---- test/serial_program_cmd_decoder_tb.sv ----
`timescale 1ns/1ps
module serial_program_cmd_decoder_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic prog_mode = 1'b0;
	logic cmd_valid = 1'b0;
	logic [31:0] cmd = 32'h0;
	logic cmd_ready, rsp_valid, sync_ok, order_err, ee_pend, enabled, busy, refused;
	logic [31:0] rsp, r;
	int mismatches = 0;
	int checks = 0;
	int seed = 20;
	logic [7:0] fl_lo [256], fl_hi [256], ee [64], pb_lo [16], pb_hi [16], eb [4];
	logic [7:0] fuse [4] = '{default: 8'hff};
	logic [7:0] fuse_wr [4] = '{8'ha0, 8'ha8, 8'ha4, 8'he0};
	logic [15:0] fuse_rd [4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
	logic [7:0] page, a;

	always #25 ref_clk = ~ref_clk;

	spd_link_if link_if ();
	// Short waits and small arrays keep the run brief; waits stay above the 512-cycle frame except erase at 500, still long enough that a poll sees busy
	localparam int SMALL_FLASH_AW = 8;
	localparam int SMALL_PAGE_AW = 4;
	localparam int SMALL_EE_AW = 6;
	localparam int SHORT_WAIT = 600;
	localparam int SHORT_ERASE = 500;
	spd_dev #(.FLASH_AW(SMALL_FLASH_AW), .PAGE_AW(SMALL_PAGE_AW), .EE_AW(SMALL_EE_AW), .FLASH_WAIT(SHORT_WAIT),
		.EE_WAIT(SHORT_WAIT), .FUSE_WAIT(SHORT_WAIT), .ERASE_WAIT(SHORT_ERASE)) i_spd_dev (.ref_clk_i(ref_clk),
		.rst_n_i(rst_n), .link(link_if), .enabled_o(enabled), .busy_o(busy));
	spd_host i_spd_host (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .link(link_if),
		.prog_mode_i(prog_mode), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
		.rsp_valid_o(rsp_valid), .rsp_o(rsp), .sync_ok_o(sync_ok), .order_err_o(order_err), .ee_pend_o(ee_pend));
	spd_monitor i_spd_monitor (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .sck(link_if.sck), .mosi(link_if.mosi),
		.miso(link_if.miso), .prog_rst_n(link_if.prog_rst_n));

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	task automatic step(inout int n);
		@(negedge ref_clk);
		n++;
		if (n > 30000)
		begin
			$display("ERROR handshake expected response seen timeout");
			mismatches++;
			conclude();
		end
	endtask

	task automatic xfer(input logic [31:0] c);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1)
			step(n);
		cmd = c;
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		refused = (order_err === 1'b1);
		while (rsp_valid !== 1'b1 && !refused)
		begin
			step(n);
			refused = refused | (order_err === 1'b1);
		end
		r = rsp;
	endtask

	// Sends one instruction and mirrors its effect in the bench's memory image
	task automatic apply(input logic [31:0] c);
		xfer(c);
		chk("busy", 1'b0, busy);
		if (!refused)
			case (c[31:24])
				spd_pkg::OP_LD_LO: pb_lo[c[11:8]] = c[7:0];
				spd_pkg::OP_LD_HI: pb_hi[c[11:8]] = c[7:0];
				spd_pkg::OP_WR_EE: ee[c[13:8]] = c[7:0];
				spd_pkg::OP_LD_EE: eb[c[9:8]] = c[7:0];
				spd_pkg::OP_WR_PAGE: for (int k = 0; k < 16; k++)
				begin
					fl_lo[{c[15:12], k[3:0]}] = pb_lo[k];
					fl_hi[{c[15:12], k[3:0]}] = pb_hi[k];
				end
				spd_pkg::OP_WR_EEPG: for (int k = 0; k < 4; k++)
					ee[{c[13:10], k[1:0]}] = eb[k];
				spd_pkg::OP_PROG: if (c[23:16] == spd_pkg::SUB_ERASE)
				begin
					fl_lo = '{default: 8'hff};
					fl_hi = '{default: 8'hff};
					ee = '{default: 8'hff};
				end
				default: ;
			endcase
	endtask

	function automatic logic [7:0] rd_exp(input logic [7:0] op, input logic [7:0] ad);
		case (op)
			spd_pkg::OP_RD_HI: return fl_hi[ad];
			spd_pkg::OP_RD_LO: return fl_lo[ad];
			default: return ee[ad[5:0]];
		endcase
	endfunction

	task automatic rd(input logic [7:0] op, input logic [7:0] ad);
		xfer({op, 8'h00, ad, 8'h00});
		chk("read", rd_exp(op, ad), r[7:0]);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		prog_mode = 1'b1;
		apply(32'haca0005a);
		chk("enabled", 1'b0, enabled);
		apply(32'hac530000);
		chk("echo", 8'h53, r[15:8]);
		chk("echo_op", spd_pkg::OP_PROG, r[23:16]);
		chk("sync", 1'b1, sync_ok);
		chk("enabled", 1'b1, enabled);
		for (int i = 0; i < 8; i++)
		begin
			if (i >= 4)
				fuse[i - 4] = (i == 4) ? 8'h00 : 8'($random(seed));
			if (i >= 4)
				apply({8'hac, fuse_wr[i - 4], 8'h00, fuse[i - 4]});
			xfer({fuse_rd[i % 4], 16'h0000});
			chk("fuse", fuse[i % 4], r[7:0]);
		end
		// Lock bits end the session unprogrammed
		fuse[3] = 8'hff;
		apply({8'hac, fuse_wr[3], 8'h00, fuse[3]});
		xfer({fuse_rd[3], 16'h0000});
		chk("lock", fuse[3], r[7:0]);
		apply(32'hac800000);
		for (int i = 0; i < 5; i++)
		begin
			a = 8'($random(seed));
			rd(spd_pkg::OP_RD_LO, a);
			rd(spd_pkg::OP_RD_HI, a);
			rd(spd_pkg::OP_RD_EE, a & 8'h3f);
		end
		page = 8'($random(seed)) & 8'hf0;
		apply(32'h4d000300);
		for (int k = 0; k < 4; k++)
		begin
			apply({spd_pkg::OP_LD_LO, 8'h00, page | 8'(k), 8'($random(seed))});
			apply({spd_pkg::OP_LD_HI, 8'h00, page | 8'(k), 8'($random(seed))});
		end
		apply({spd_pkg::OP_LD_HI, 8'h00, page | 8'h0f, 8'h12});
		chk("order_err", 1'b1, refused);
		apply({spd_pkg::OP_WR_PAGE, 8'h00, page, 8'h00});
		for (int k = 0; k < 4; k++)
		begin
			rd(spd_pkg::OP_RD_LO, page | 8'(k));
			rd(spd_pkg::OP_RD_HI, page | 8'(k));
		end
		a = 8'($random(seed)) & 8'h3f;
		apply({spd_pkg::OP_WR_EE, 8'h00, a, 8'($random(seed))});
		rd(spd_pkg::OP_RD_EE, a);
		a = 8'($random(seed)) & 8'h3c;
		for (int k = 0; k < 4; k++)
			apply({spd_pkg::OP_LD_EE, 8'h00, a | 8'(k), 8'($random(seed))});
		chk("ee_pend", 1'b1, ee_pend);
		apply({spd_pkg::OP_WR_EEPG, 8'h00, a, 8'h00});
		chk("ee_pend", 1'b0, ee_pend);
		for (int k = 0; k < 4; k++)
			rd(spd_pkg::OP_RD_EE, a | 8'(k));
		apply(32'hf0000000);
		chk("poll", 1'b0, r[0]);
		prog_mode = 1'b0;
		repeat (20) @(negedge ref_clk);
		chk("enabled", 1'b0, enabled);
		prog_mode = 1'b1;
		xfer({spd_pkg::OP_RD_EE, 8'h00, a, 8'h00});
		chk("unenabled_read", a, r[7:0]);
		apply(32'hac530000);
		rd(spd_pkg::OP_RD_EE, a);
		conclude();
	end
endmodule
